//--- eap_channel.sv
`timescale 1ns/1ns
//Behaviour
// R01: PWM only when center off, B set, select nonzero
// R02: PWM mode forces pin to output
// R03: High-true: high at zero, low on match
// R04: Select low bit set: high on match
// R05: Low-true: low at period start
module eap_channel
    import eap_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic center_aligned_select_in,
    input wire logic channel_mode_select_b_in,
    input wire logic edge_level_select_hi_in,
    input wire logic edge_level_select_lo_in,
    input wire logic [EAP_CNT_W-1:0] timer_up_count_in,
    input wire logic [EAP_CNT_W-1:0] compare_value_in,
    input wire logic port_dir_out_in, // Port logic direction, 1 = output
    input wire logic port_data_in, // Port logic output level
    input wire logic channel_output_pin_in, // Pin level read back
    output logic channel_output_pin_out,
    output logic channel_output_pin_oe_n_out, // Low while driving
    output logic pwm_active_out
);
    eap_cmp_if cmp ();

    // Decoder instance
    eap_decode u_dec (
        .center_aligned_select_in(center_aligned_select_in),
        .channel_mode_select_b_in(channel_mode_select_b_in),
        .edge_level_select_hi_in(edge_level_select_hi_in),
        .edge_level_select_lo_in(edge_level_select_lo_in),
        .timer_up_count_in(timer_up_count_in),
        .compare_value_in(compare_value_in),
        .cmp(cmp.src)
    );

    // Waveform state and its next value
    logic pwm_level; // Timer-driven level
    logic next_pwm_level; // Its next value

    // Level that a compare event leaves behind for a polarity
    function automatic logic eap_event_level(input logic low_true,
                                             input logic at_match);
        // High-true: low on match, high at start; low-true inverts
        if (at_match) begin
            return low_true;
        end
        return !low_true;
    endfunction

    // Next waveform level; a match wins over period start
    always_comb begin
        next_pwm_level = pwm_level; // Hold between events
        if (cmp.match) begin
            // Compare value equals the counter
            next_pwm_level = eap_event_level(cmp.low_true, 1'b1); // R03 R04
        end else if (cmp.period_start) begin
            // Counter back at the start of a period
            next_pwm_level = eap_event_level(cmp.low_true, 1'b0); // R03 R05
        end
    end

    // Waveform register; keeps tracking outside PWM mode too
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_level <= EAP_PIN_RST; // Starts low
        end else if (clk_en_in) begin
            pwm_level <= next_pwm_level; // Frozen while enable low
        end
    end

    // Pin level: timer level in PWM mode, port data otherwise
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            channel_output_pin_out <= EAP_PIN_RST;
        end else if (clk_en_in) begin
            if (cmp.pwm_active) begin
                // Timer owns the pin
                channel_output_pin_out <= next_pwm_level; // R02
            end else begin
                // Port logic owns the pin
                channel_output_pin_out <= port_data_in;
            end
        end
    end

    // Output enable: forced on in PWM mode, port direction otherwise
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            channel_output_pin_oe_n_out <= EAP_OE_N_RST; // Released
        end else if (clk_en_in) begin
            if (cmp.pwm_active) begin
                // Direction setting ignored
                channel_output_pin_oe_n_out <= 1'b0; // R02
            end else begin
                // Drive only when the port is an output
                channel_output_pin_oe_n_out <= !port_dir_out_in;
            end
        end
    end

    // Mode flag for the rest of the timer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_active_out <= EAP_ACT_RST;
        end else if (clk_en_in) begin
            pwm_active_out <= cmp.pwm_active; // R01
        end
    end

    // Checks: named steps of the waveform
    // High-true PWM with a compare event
    sequence s_high_match;
        cmp.pwm_active && !cmp.low_true && cmp.match;
    endsequence
    // Low-true PWM at period start, no compare event
    sequence s_low_start;
        cmp.pwm_active && cmp.low_true && cmp.period_start && !cmp.match;
    endsequence
    // PWM mode with neither event this cycle
    sequence s_pwm_quiet;
        cmp.pwm_active && !cmp.match && !cmp.period_start;
    endsequence
    // Any mode with neither event this cycle
    sequence s_no_event;
        !cmp.match && !cmp.period_start;
    endsequence
    // Compare event and period start in one cycle
    sequence s_both_events;
        cmp.pwm_active && cmp.match && cmp.period_start;
    endsequence
    // Mode bits that select edge-aligned PWM
    sequence s_mode_on;
        !center_aligned_select_in && channel_mode_select_b_in
            && (edge_level_select_hi_in || edge_level_select_lo_in);
    endsequence

    // Registered mode flag follows the decode
    mode_select_a: assert property ( // R01
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in |=> pwm_active_out == $past(cmp.pwm_active))
        else $error("pwm mode decode wrong");

    // Mode flag set for a legal mode selection
    mode_on_a: assert property ( // R01
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in ##0 s_mode_on |=> pwm_active_out)
        else $error("pwm mode not decoded");

    // Mode flag clear for any other selection
    mode_off_a: assert property ( // R01
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in && (center_aligned_select_in || !channel_mode_select_b_in
        || {edge_level_select_hi_in, edge_level_select_lo_in} == EAP_ELS_OFF)
        |=> !pwm_active_out)
        else $error("pwm mode decoded when off");

    // Pin driven whenever PWM mode is decoded
    pin_override_a: assert property ( // R02
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in && cmp.pwm_active |=> !channel_output_pin_oe_n_out)
        else $error("pin not driven in pwm mode");

    // Port logic owns the pin outside PWM mode
    port_pass_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in && !cmp.pwm_active |=> channel_output_pin_out
        == $past(port_data_in)
        && channel_output_pin_oe_n_out == !$past(port_dir_out_in))
        else $error("port level or direction not passed");

    // High-true pin rises at period start
    high_true_a: assert property ( // R03
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in && cmp.pwm_active && !cmp.low_true && cmp.period_start
        && !cmp.match |=> channel_output_pin_out)
        else $error("high-true pin not high at start");

    // High-true pin falls on compare
    high_match_a: assert property ( // R03
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in ##0 s_high_match |=> !channel_output_pin_out)
        else $error("high-true pin not low on match");

    // Low-true pin rises on compare
    low_match_a: assert property ( // R04
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in && cmp.pwm_active && cmp.low_true && cmp.match
        |=> channel_output_pin_out)
        else $error("low-true pin not high on match");

    // Low-true pin falls at period start
    low_start_a: assert property ( // R05
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in ##0 s_low_start |=> !channel_output_pin_out)
        else $error("low-true pin not low at start");

    // Compare event wins over a coincident period start
    match_wins_a: assert property ( // R03 R04
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in ##0 s_both_events |=> channel_output_pin_out
        == $past(cmp.low_true))
        else $error("period start beat the compare event");

    // Pin holds its level between events in PWM mode
    pwm_hold_a: assert property ( // R03 R05
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in ##0 s_pwm_quiet |=> channel_output_pin_out
        == $past(pwm_level))
        else $error("pin moved without an event");

    // Waveform level holds between events in any mode
    level_hold_a: assert property ( // R03
        @(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in ##0 s_no_event |=> $stable(pwm_level))
        else $error("waveform level moved without an event");

    // Clock enable low freezes the pin level
    pin_freeze_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !clk_en_in |=> $stable(channel_output_pin_out))
        else $error("pin level moved while frozen");

    // Clock enable low freezes the output enable
    oe_freeze_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !clk_en_in |=> $stable(channel_output_pin_oe_n_out))
        else $error("output enable moved while frozen");

    // Clock enable low freezes the mode flag
    mode_freeze_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !clk_en_in |=> $stable(pwm_active_out))
        else $error("mode flag moved while frozen");

    // Clock enable low freezes the waveform level
    level_freeze_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !clk_en_in |=> $stable(pwm_level))
        else $error("waveform level moved while frozen");
endmodule // eap_channel

//--- eap_cmp_if.sv
`timescale 1ns/1ns
// Mode and compare events passed from decoder to output stage
interface eap_cmp_if;
    import eap_pkg::*;
    logic pwm_active; // Edge-aligned PWM selected
    logic low_true; // Low-true polarity chosen
    logic period_start; // Counter at period start
    logic match; // Compare equals counter
    modport src (output pwm_active, output low_true,
                 output period_start, output match);
    modport dst (input pwm_active, input low_true,
                 input period_start, input match);
endinterface // eap_cmp_if

//--- eap_decode.sv
`timescale 1ns/1ns
// Mode decode and counter comparisons, purely combinational
module eap_decode
    import eap_pkg::*;
(
    input wire logic center_aligned_select_in,
    input wire logic channel_mode_select_b_in,
    input wire logic edge_level_select_hi_in,
    input wire logic edge_level_select_lo_in,
    input wire logic [EAP_CNT_W-1:0] timer_up_count_in,
    input wire logic [EAP_CNT_W-1:0] compare_value_in,
    eap_cmp_if.src cmp
);
    // Mode select and polarity
    always_comb begin
        cmp.pwm_active = !center_aligned_select_in && channel_mode_select_b_in
            && ({edge_level_select_hi_in, edge_level_select_lo_in}
                != EAP_ELS_OFF); // R01
        cmp.low_true = edge_level_select_lo_in; // R04
    end
    // Counter comparisons
    always_comb begin
        cmp.period_start = (timer_up_count_in == EAP_PERIOD_START);
        cmp.match = (timer_up_count_in == compare_value_in);
    end
endmodule // eap_decode

//--- eap_pkg.sv
package eap_pkg;
    // Counter and compare width
    localparam int EAP_CNT_W = 16;
    // Counter value that opens each period
    localparam logic [15:0] EAP_PERIOD_START = 16'h0000;
    // Pin level after reset
    localparam logic EAP_PIN_RST = 1'b0;
    // Output enable after reset, pin released
    localparam logic EAP_OE_N_RST = 1'b1;
    // Mode flag after reset
    localparam logic EAP_ACT_RST = 1'b0;
    // Edge/level select code that turns the channel off
    localparam logic [1:0] EAP_ELS_OFF = 2'h0;
endpackage : eap_pkg

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
    import eap_pkg::*;
    logic clk_in = 0, rst_n_in = 0, clk_en_in = 0; // Clock, reset, enable
    logic cas = 0, msb = 0, hi = 0, lo = 0, dir = 0, dat = 0; // Mode, port
    logic [EAP_CNT_W-1:0] cnt = '0, cmp = '0; // Counter and compare
    logic pin, oe_n, act; // Design outputs
    logic [31:0] seed = 32'hebdd; // Random state
    logic [3:0] q[$]; // Notes {pin valid, pin, oe_n, active}
    logic [3:0] exp_v, last = 4'h2; // Popped and latest note
    logic wave = 0, known = 0, pwm = 0; // Reference waveform
    int n_errors = 0, n_checks = 0;
    // Free-running clock
    always #20 clk_in = ~clk_in;
    eap_channel uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in), .center_aligned_select_in(cas),
        .channel_mode_select_b_in(msb), .edge_level_select_hi_in(hi),
        .edge_level_select_lo_in(lo), .timer_up_count_in(cnt),
        .compare_value_in(cmp), .port_dir_out_in(dir), .port_data_in(dat),
        .channel_output_pin_in(pin), .channel_output_pin_out(pin),
        .channel_output_pin_oe_n_out(oe_n), .pwm_active_out(act));
    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Counts and verdict
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One comparison
    task automatic chk(input string nm, input logic e, input logic s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", nm, e, s);
        end
    endtask
    // Monitor: oldest note against settled outputs
    always @(posedge clk_in) begin
        if (q.size() > 0) begin
            #1 exp_v = q.pop_front();
            if (exp_v[3]) chk("pin", exp_v[2], pin);
            chk("oe_n", exp_v[1], oe_n);
            chk("pwm_active", exp_v[0], act);
        end
    end
    // Driver and reference model
    initial begin
        repeat (3) @(negedge clk_in);
        chk("pin_rst", EAP_PIN_RST, pin);
        chk("oe_rst", EAP_OE_N_RST, oe_n);
        chk("act_rst", EAP_ACT_RST, act);
        rst_n_in = 1;
        for (int i = 0; i < 2000; i++) begin
            @(negedge clk_in);
            seed = xs(seed);
            // New mode and compare every three periods
            if (i % 27 == 0) begin
                {cas, msb, hi, lo} = seed[3:0];
                cmp = 16'(seed[19:16] % 10);
            end
            cnt = 16'(i % 9);
            {dir, dat} = seed[9:8];
            clk_en_in = (seed[12:10] != 3'h0);
            if (clk_en_in) begin
                pwm = !cas && msb && (hi || lo);
                if (cnt == cmp) begin
                    wave = lo;
                    known = 1;
                end else if (cnt == EAP_PERIOD_START) begin
                    wave = !lo;
                    known = 1;
                end
                last = pwm ? {known, wave, 2'b01} : {1'b1, dat, !dir, 1'b0};
            end
            q.push_back(last);
        end
        // Bounded drain
        for (int k = 0; k < 4 && q.size() > 0; k++) @(negedge clk_in);
        if (q.size() > 0) begin
            n_errors++;
            $display("ERROR drain expected 0 seen %0d", q.size());
        end
        wrap_up();
    end
endmodule // testbench
